/* hw/ecv_pkg.sv */
package ecv_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SAW    = 8'h70;
    localparam logic [7:0] IDX_SPRING = 8'h71;
    localparam logic [7:0] IDX_DELAY  = 8'h72;
    localparam logic [7:0] IDX_VDI    = 8'h73;
    localparam logic [7:0] IDX_VDHG   = 8'h74;
    localparam logic [7:0] IDX_VCI    = 8'h75;
    localparam logic [7:0] IDX_CTRL   = 8'h7e;
    localparam logic [7:0] IDX_STAT   = 8'h7f;

    localparam logic [7:0] RST_SAW    = 8'h00;
    localparam logic [7:0] RST_SPRING = 8'h44;
    localparam logic [7:0] RST_DELAY  = 8'h0f;
    localparam logic [7:0] RST_VDI    = 8'h77;
    localparam logic [7:0] RST_VDHG   = 8'h74;
    localparam logic [7:0] RST_VCI    = 8'h85;
    localparam logic [4:0] RST_CTRL   = 5'h00;

    // Control register bits
    localparam int CTL_UNLOCK = 0;
    localparam int CTL_HYST   = 1;
    localparam int CTL_MULAW  = 2;
    localparam int CTL_SLAVE  = 3;
    localparam int CTL_SAW_EN = 4;

    localparam int SAW_RISE_LSB  = 5;
    localparam int SAW_FALL_LSB  = 2;
    localparam int SPR_AUX_LSB   = 4;
    localparam int VDI_MAX_LSB   = 4;
    localparam int VDHG_HANG_LSB = 4;

    // Timing: one base tick is 250 us (4 kHz ramp, shortest spring)
    localparam int CLK_PERIOD_NS  = 10;
    localparam int BASE_TICK_NS   = 250000;
    localparam int BASE_TICK_CYC  = BASE_TICK_NS / CLK_PERIOD_NS;
    localparam int WIN_STEP_MS    = 8;
    localparam int WIN_STEP_TICKS = WIN_STEP_MS * 1000000 / BASE_TICK_NS;

    localparam logic [13:0] LIM_ALAW     = 14'h1f80;
    localparam logic [13:0] LIM_MULAW    = 14'h1f5f;
    localparam logic [11:0] NV_THR_SHORT = 12'h200;
    localparam logic [11:0] NV_THR_LONG  = 12'h400;
    localparam logic [1:0]  LONG_MODE_CODE  = 2'h3;
    localparam logic [3:0]  DELAY_CAP_SHORT = 4'h7;

    localparam logic [3:0][6:0] AMP_TBL = {7'h7f, 7'h3f, 7'h1f, 7'h0f};
    // Linear factor x16 for 0..45 dB in 3 dB steps
    localparam logic [15:0][11:0] DB_TBL = {
        12'hb18, 12'h7da, 12'h58f, 12'h3ef, 12'h2c9, 12'h1f9, 12'h165,
        12'h0fd, 12'h0b3, 12'h07f, 12'h05a, 12'h040, 12'h02d, 12'h020,
        12'h017, 12'h010};

    typedef enum logic [0:0] {
        SAW_UP   = 1'b0,
        SAW_DOWN = 1'b1
    } ecv_saw_dir_t;
endpackage

/* hw/ecv_top.sv */
`timescale 1ns/1ns
`default_nettype none
module ecv_top
    import ecv_pkg::*;
#(
    parameter int BASE_CYC = BASE_TICK_CYC
)(
    input  wire logic        SYS_CLK_I,
    input  wire logic        SRST_I,
    input  wire logic [9:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output var  logic [31:0] AVS_READDATA_O,
    output var  logic        AVS_WAITREQUEST_O,
    input  wire logic        OPERATING_MODE_PIN_A_I,
    input  wire logic        OPERATING_MODE_PIN_B_I,
    input  wire logic        COEF_FROZEN_I,
    input  wire logic        RX_VALID_I,
    input  wire logic [13:0] RX_SAMPLE_I,
    input  wire logic [4:0]  CHANNEL_I,
    output var  logic        RX_VALID_O,
    output var  logic [13:0] RX_SAMPLE_O,
    output var  logic        CHANNEL_OWNED_O,
    output var  logic        AUX_DAMP_PULSE_O,
    output var  logic        COEF_DAMP_PULSE_O,
    output var  logic        NO_VOICE_O,
    output var  logic [3:0]  EFF_DELAY_O,
    output var  logic        LONG_MODE_O
);

    typedef struct packed {
        logic [1:0]   mode_s1;
        logic [1:0]   mode_s2;
        logic         ack;
        logic [31:0]  rdata;
        logic [7:0]   st_cfg;
        logic [7:0]   spr_cfg;
        logic [7:0]   dly;
        logic [7:0]   vdi;
        logic [7:0]   vdhg;
        logic [7:0]   vci;
        logic [4:0]   ctl;
        logic [15:0]  pre;
        logic [7:0]   div;
        logic [6:0]   saw;
        ecv_saw_dir_t dir;
        logic [13:0]  smp;
        logic         smp_vld;
        logic         owned;
        logic         aux_p;
        logic         coef_p;
        logic [9:0]   pk_cnt;
        logic [13:0]  run_max;
        logic [13:0]  peak;
        logic [9:0]   dt_cnt;
        logic [11:0]  qcnt;
        logic         crit;
        logic [9:0]   hang;
        logic         no_voice;
    } ecv_state_t;

    ecv_state_t s_q;
    ecv_state_t s_d;

    function automatic logic [7:0] ecv_mask(input logic [2:0] c);
        ecv_mask = 8'((9'h001 << c) - 9'h001);
    endfunction

    function automatic logic [9:0] ecv_win(input logic [3:0] c);
        ecv_win = 10'(({6'h00, c} + 10'h001) * WIN_STEP_TICKS);
    endfunction

    logic        long_mode;
    logic        req;
    logic [7:0]  idx;
    logic        aligned;
    logic [31:0] rd_mux;
    logic        wr_ok;
    logic        tick;
    logic [2:0]  rise_c;
    logic [2:0]  fall_c;
    logic [6:0]  amp;
    logic        rise_tk;
    logic        fall_tk;
    logic [14:0] sum;
    logic [14:0] lim15;
    logic [13:0] lim;
    logic [13:0] mag;
    logic [25:0] prod;
    logic [25:0] pk16;
    logic        qual;
    logic        pk_end;
    logic        dt_end;
    logic [13:0] max_new;
    logic [11:0] q_inc;
    logic [11:0] q_init;
    logic [11:0] q_thr;
    logic        crit_new;
    logic [3:0]  eff;

    assign long_mode = (s_q.mode_s2 == LONG_MODE_CODE);
    assign req       = AVS_READ_I | AVS_WRITE_I;
    assign idx       = AVS_ADDRESS_I[9:2];
    assign aligned   = (AVS_ADDRESS_I[1:0] == 2'h0);
    assign tick      = (s_q.pre == 16'(BASE_CYC - 1));

    always_comb
    begin
        s_d      = s_q;
        rd_mux   = 32'h0000_0000;
        wr_ok    = 1'b0;
        rise_c   = s_q.st_cfg[SAW_RISE_LSB +: 3];
        fall_c   = s_q.st_cfg[SAW_FALL_LSB +: 3];
        amp      = AMP_TBL[s_q.st_cfg[1:0]];
        rise_tk  = 1'b0;
        fall_tk  = 1'b0;
        sum      = 15'h0000;
        lim      = LIM_ALAW;
        lim15    = 15'h0000;
        mag      = 14'h0000;
        prod     = 26'h0;
        pk16     = 26'h0;
        qual     = 1'b0;
        pk_end   = 1'b0;
        dt_end   = 1'b0;
        max_new  = s_q.run_max;
        q_inc    = s_q.qcnt;
        q_init   = 12'h000;
        q_thr    = NV_THR_SHORT;
        crit_new = s_q.crit;
        eff      = s_q.dly[3:0];

        // ------------------------------------------------------------
        // Mode pin synchronisers
        // ------------------------------------------------------------
        s_d.mode_s1 = {OPERATING_MODE_PIN_B_I, OPERATING_MODE_PIN_A_I};
        s_d.mode_s2 = s_q.mode_s1;

        // Delay cap first, so the status read sees the capped value
        if (!long_mode && s_q.dly[3])
        begin
            eff = DELAY_CAP_SHORT;
        end

        // ------------------------------------------------------------
        // Avalon-MM slave, one wait cycle per access
        // ------------------------------------------------------------
        case (idx)
            IDX_SAW:    rd_mux = {24'h000000, s_q.st_cfg};
            IDX_SPRING: rd_mux = {24'h000000, s_q.spr_cfg & 8'h77};
            IDX_DELAY:  rd_mux = {28'h0000000, s_q.dly[3:0]};
            IDX_VDI:    rd_mux = {24'h000000, s_q.vdi};
            IDX_VDHG:   rd_mux = {24'h000000, s_q.vdhg};
            IDX_VCI:    rd_mux = {24'h000000, s_q.vci};
            IDX_CTRL:   rd_mux = {27'h0000000, s_q.ctl};
            IDX_STAT:   rd_mux = {26'h0000000, long_mode, s_q.no_voice,
                                  eff};
            default:    rd_mux = 32'h0000_0000;
        endcase
        if (!aligned)
        begin
            rd_mux = 32'h0000_0000;
        end
        s_d.ack = req & ~s_q.ack;
        if (AVS_READ_I && !s_q.ack)
        begin
            s_d.rdata = rd_mux;
        end
        wr_ok = AVS_WRITE_I & s_q.ack & AVS_BYTEENABLE_I[0] & aligned;
        if (wr_ok && idx == IDX_CTRL)
        begin
            s_d.ctl = AVS_WRITEDATA_I[4:0];
        end
        if (wr_ok && s_q.ctl[CTL_UNLOCK])
        begin
            case (idx)
                IDX_SAW:    s_d.st_cfg  = AVS_WRITEDATA_I[7:0];
                IDX_SPRING: s_d.spr_cfg = AVS_WRITEDATA_I[7:0] & 8'h77;
                IDX_DELAY:  s_d.dly     = {4'h0, AVS_WRITEDATA_I[3:0]};
                IDX_VDI:    s_d.vdi     = AVS_WRITEDATA_I[7:0];
                IDX_VDHG:   s_d.vdhg    = AVS_WRITEDATA_I[7:0];
                IDX_VCI:    s_d.vci     = AVS_WRITEDATA_I[7:0];
                default:    s_d.vci     = s_q.vci;
            endcase
        end

        // ------------------------------------------------------------
        // Time base and spring timers
        // ------------------------------------------------------------
        s_d.pre = tick ? 16'h0000 : s_q.pre + 16'h0001;
        if (tick)
        begin
            s_d.div = s_q.div + 8'h01;
        end
        s_d.aux_p  = tick && !COEF_FROZEN_I &&
            ((s_q.div & ecv_mask(s_q.spr_cfg[SPR_AUX_LSB +: 3]))
              == ecv_mask(s_q.spr_cfg[SPR_AUX_LSB +: 3]));
        s_d.coef_p = tick && !COEF_FROZEN_I &&
            ((s_q.div & ecv_mask(s_q.spr_cfg[2:0]))
              == ecv_mask(s_q.spr_cfg[2:0]));

        // ------------------------------------------------------------
        // Saw-tooth generator
        // ------------------------------------------------------------
        rise_tk = tick && ((s_q.div & ecv_mask(rise_c))
                           == ecv_mask(rise_c));
        fall_tk = tick && ((s_q.div & ecv_mask(fall_c))
                           == ecv_mask(fall_c));
        if (rise_c == 3'h0 && fall_c == 3'h0)
        begin
            s_d.saw = amp;
            s_d.dir = SAW_DOWN;
        end
        else
        begin
            case (s_q.dir)
                SAW_UP:
                begin
                    if (s_q.saw >= amp)
                    begin
                        s_d.dir = SAW_DOWN;
                    end
                    else if (rise_tk)
                    begin
                        s_d.saw = s_q.saw + 7'h01;
                    end
                end
                SAW_DOWN:
                begin
                    if (s_q.saw == 7'h00)
                    begin
                        s_d.dir = SAW_UP;
                    end
                    else if (fall_tk)
                    begin
                        s_d.saw = s_q.saw - 7'h01;
                    end
                end
                default: s_d.dir = SAW_UP;
            endcase
        end

        // ------------------------------------------------------------
        // Receive path offset and clipping
        // ------------------------------------------------------------
        sum = {RX_SAMPLE_I[13], RX_SAMPLE_I} +
              (s_q.ctl[CTL_SAW_EN] ? {8'h00, s_q.saw} : 15'h0000);
        lim   = s_q.ctl[CTL_MULAW] ? LIM_MULAW : LIM_ALAW;
        lim15 = {1'b0, lim};
        s_d.smp_vld = RX_VALID_I;
        if (RX_VALID_I)
        begin
            if ($signed(sum) > $signed(lim15))
            begin
                s_d.smp = lim;
            end
            else if ($signed(sum) < -$signed(lim15))
            begin
                s_d.smp = ~lim + 14'h0001;
            end
            else
            begin
                s_d.smp = sum[13:0];
            end
        end

        // ------------------------------------------------------------
        // Tandem channel split (echo delay cap is applied above)
        // ------------------------------------------------------------
        s_d.owned = !long_mode ||
                    (CHANNEL_I[2] == s_q.ctl[CTL_SLAVE]);

        // ------------------------------------------------------------
        // No-voice detection
        // ------------------------------------------------------------
        mag  = RX_SAMPLE_I[13] ? ~RX_SAMPLE_I + 14'h0001 : RX_SAMPLE_I;
        prod = {12'h000, mag} * {14'h0000, DB_TBL[s_q.vdhg[3:0]]};
        pk16 = {8'h00, s_q.peak, 4'h0};
        qual = RX_VALID_I && (pk16 < prod);
        if (RX_VALID_I && mag > s_q.run_max)
        begin
            max_new = mag;
        end
        pk_end = tick && (s_q.pk_cnt >=
                 ecv_win(s_q.vdi[VDI_MAX_LSB +: 4]) - 10'h001);
        dt_end = tick && (s_q.dt_cnt >=
                 ecv_win(s_q.vdi[3:0]) - 10'h001);
        s_d.run_max = max_new;
        if (tick)
        begin
            s_d.pk_cnt = s_q.pk_cnt + 10'h001;
            s_d.dt_cnt = s_q.dt_cnt + 10'h001;
        end
        if (pk_end)
        begin
            s_d.peak    = max_new;
            s_d.run_max = 14'h0000;
            s_d.pk_cnt  = 10'h000;
        end
        if (qual && s_q.qcnt != 12'hfff)
        begin
            q_inc = s_q.qcnt + 12'h001;
        end
        s_d.qcnt = q_inc;
        q_init = long_mode ? {2'h0, s_q.vci, 2'h0}
                           : {3'h0, s_q.vci, 1'b0};
        q_thr  = long_mode ? NV_THR_LONG : NV_THR_SHORT;
        if (tick && s_q.hang != 10'h000)
        begin
            s_d.hang = s_q.hang - 10'h001;
        end
        if (dt_end)
        begin
            crit_new   = (q_inc >= q_thr);
            s_d.crit   = crit_new;
            s_d.qcnt   = q_init;
            s_d.dt_cnt = 10'h000;
            if (crit_new)
            begin
                s_d.hang = ecv_win(s_q.vdhg[VDHG_HANG_LSB +: 4]);
            end
        end
        s_d.no_voice = s_d.crit ||
            (s_q.ctl[CTL_HYST] && s_d.hang != 10'h000);
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (SRST_I)
        begin
            s_q         <= '0;
            s_q.st_cfg  <= RST_SAW;
            s_q.spr_cfg <= RST_SPRING;
            s_q.dly     <= RST_DELAY;
            s_q.vdi     <= RST_VDI;
            s_q.vdhg    <= RST_VDHG;
            s_q.vci     <= RST_VCI;
            s_q.ctl     <= RST_CTRL;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign AVS_WAITREQUEST_O = req & ~s_q.ack;
    assign AVS_READDATA_O    = s_q.rdata;
    assign RX_VALID_O        = s_q.smp_vld;
    assign RX_SAMPLE_O       = s_q.smp;
    assign CHANNEL_OWNED_O   = s_q.owned;
    assign AUX_DAMP_PULSE_O  = s_q.aux_p;
    assign COEF_DAMP_PULSE_O = s_q.coef_p;
    assign NO_VOICE_O        = s_q.no_voice;
    assign EFF_DELAY_O       = eff;
    assign LONG_MODE_O       = long_mode;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);

    a_write_protect: assert property (
        (AVS_WRITE_I && !AVS_WAITREQUEST_O && idx == IDX_DELAY &&
         !s_q.ctl[CTL_UNLOCK]) |=> $stable(s_q.dly))
        else $error("delay written while locked");
    a_delay_cap: assert property (
        (!long_mode && s_q.dly[3]) |-> EFF_DELAY_O == 4'h7)
        else $error("short mode delay not capped");
    a_ramp_stopped: assert property (
        (rise_c == 3'h0 && fall_c == 3'h0) |=> s_q.saw == $past(amp))
        else $error("offset not constant");
    a_saw_step: assert property (
        ((rise_c != 3'h0 || fall_c != 3'h0) && $stable(s_q.st_cfg))
        |=> (s_q.saw == $past(s_q.saw) ||
             s_q.saw == $past(s_q.saw) + 7'h01 ||
             s_q.saw == $past(s_q.saw) - 7'h01))
        else $error("saw-tooth jumped");
    a_clip_limit: assert property (
        RX_VALID_O |-> ($signed(RX_SAMPLE_O) <= $signed(14'h1f80) &&
                        $signed(RX_SAMPLE_O) >= $signed(14'h2080)))
        else $error("sample beyond limit");
    a_frozen_damp: assert property (
        $past(COEF_FROZEN_I) |-> !AUX_DAMP_PULSE_O && !COEF_DAMP_PULSE_O)
        else $error("damping while frozen");
    a_damp_single: assert property (
        AUX_DAMP_PULSE_O |=> !AUX_DAMP_PULSE_O [*3])
        else $error("damping pulse too long");
    a_nv_thresh: assert property (
        (dt_end && q_inc >= q_thr) |=> s_q.crit ##1 NO_VOICE_O)
        else $error("no-voice not declared");
    a_hyst_off: assert property (
        !$past(s_q.ctl[CTL_HYST]) |-> NO_VOICE_O == s_q.crit)
        else $error("no-voice held without hysteresis");
    a_tandem_split: assert property (
        long_mode && $stable(long_mode) |=>
        CHANNEL_OWNED_O == ($past(CHANNEL_I[2]) == $past(s_q.ctl[CTL_SLAVE])))
        else $error("wrong channel split");
    a_bus_answer: assert property (
        (req && AVS_WAITREQUEST_O) |=> !AVS_WAITREQUEST_O)
        else $error("bus answer late");

    c_nv_on:   cover property (!NO_VOICE_O ##1 NO_VOICE_O);
    c_saw_top: cover property (s_q.dir == SAW_UP ##1 s_q.dir == SAW_DOWN);
    c_aux_p:   cover property (AUX_DAMP_PULSE_O);
    c_write:   cover property (wr_ok && s_q.ctl[CTL_UNLOCK]);
endmodule
`default_nettype wire

/* testbench/tb_ecv_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_ecv_top
    import ecv_pkg::*;
;
    localparam int BC = 20;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [9:0]  addr = '0;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic        waitreq;
    logic        mode_a = 1'b0;
    logic        mode_b = 1'b0;
    logic        frozen = 1'b0;
    logic        rx_v = 1'b0;
    logic [13:0] rx_s = '0;
    logic [4:0]  chan = '0;
    logic        rxo_v;
    logic [13:0] rxo_s;
    logic        owned;
    logic        aux_p;
    logic        coef_p;
    logic        no_voice;
    logic [3:0]  eff_dly;
    logic        long_m;
    int          fail_count = 0;
    int          comparisons = 0;
    logic [31:0] r;
    int          na;
    int          nc;
    int          t_off;
    int          t_on;
    logic [13:0] lo;
    logic [13:0] hi;
    logic [7:0]  ridx [7] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h7e};
    logic [7:0]  rval [7] = '{8'h00, 8'h44, 8'h0f, 8'h77, 8'h74, 8'h85, 8'h00};

    always #5 clk = ~clk;

    ecv_top #(.BASE_CYC(BC)) i_dut (
        .SYS_CLK_I              (clk),
        .SRST_I                 (srst),
        .AVS_ADDRESS_I          (addr),
        .AVS_READ_I             (rd_en),
        .AVS_WRITE_I            (wr_en),
        .AVS_WRITEDATA_I        (wdata),
        .AVS_BYTEENABLE_I       (4'hf),
        .AVS_READDATA_O         (rdata),
        .AVS_WAITREQUEST_O      (waitreq),
        .OPERATING_MODE_PIN_A_I (mode_a),
        .OPERATING_MODE_PIN_B_I (mode_b),
        .COEF_FROZEN_I          (frozen),
        .RX_VALID_I             (rx_v),
        .RX_SAMPLE_I            (rx_s),
        .CHANNEL_I              (chan),
        .RX_VALID_O             (rxo_v),
        .RX_SAMPLE_O            (rxo_s),
        .CHANNEL_OWNED_O        (owned),
        .AUX_DAMP_PULSE_O       (aux_p),
        .COEF_DAMP_PULSE_O      (coef_p),
        .NO_VOICE_O             (no_voice),
        .EFF_DELAY_O            (eff_dly),
        .LONG_MODE_O            (long_m)
    );

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request held until the edge where waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= {idx, 2'b00};
        wdata <= {24'h0, wd};
        rd_en <= ~wr;
        wr_en <= wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitreq !== 1'b0 && n < 50);
        rd = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        if (n >= 50)
        begin
            check("bus timeout", 32'h1, 32'h0);
            test_done();
        end
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rreg(input logic [7:0] idx, output logic [31:0] d);
        bus(1'b0, idx, 8'h00, d);
    endtask

    task automatic send(input logic [13:0] s, input logic [13:0] exp);
        @(posedge clk);
        rx_v <= 1'b1;
        rx_s <= s;
        @(posedge clk);
        rx_v <= 1'b0;
        @(negedge clk);
        check("rx valid", {31'h0, rxo_v}, 32'h1);
        check("rx sample", {18'h0, rxo_s}, {18'h0, exp});
    endtask

    task automatic pulses(output int a, output int c);
        a = 0;
        c = 0;
        repeat (200)
        begin
            @(negedge clk);
            a += int'(aux_p === 1'b1);
            c += int'(coef_p === 1'b1);
        end
    endtask

    // Feed steady samples, stop, then time how long no-voice lingers
    task automatic nv_run(input logic hyst, output int fall);
        wreg(8'h7e, {6'h0, hyst, 1'b1});
        repeat (2600)
        begin
            @(posedge clk);
            rx_v <= 1'b1;
            rx_s <= 14'd1000;
        end
        @(posedge clk);
        rx_v <= 1'b0;
        @(negedge clk);
        check("no voice set", {31'h0, no_voice}, 32'h1);
        fall = 0;
        while (no_voice !== 1'b0 && fall < 5000)
        begin
            @(negedge clk);
            fall++;
        end
        check("no voice cleared", {31'h0, no_voice}, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        foreach (ridx[i])
        begin
            rreg(ridx[i], r);
            check("reset value", r, {24'h0, rval[i]});
        end
        rreg(8'h7f, r);
        check("status", r, 32'h7);
        rreg(8'h40, r);
        check("unmapped", r, 32'h0);
        $display("test reset done");

        wreg(8'h72, 8'h03);
        rreg(8'h72, r);
        check("locked write", r, 32'h0f);
        wreg(8'h7e, 8'h01);
        wreg(8'h72, 8'h03);
        @(negedge clk);
        check("delay", {28'h0, eff_dly}, 32'h3);
        wreg(8'h72, 8'h0a);
        rreg(8'h72, r);
        check("delay reg", r, 32'h0a);
        @(negedge clk);
        check("delay cap", {28'h0, eff_dly}, 32'h7);
        $display("test delay done");

        send(14'd8100, 14'd8064);
        send(-14'sd8100, -14'sd8064);
        wreg(8'h7e, 8'h05);
        send(14'd8100, 14'd8031);
        wreg(8'h7e, 8'h11);
        for (int k = 0; k < 4; k++)
        begin
            wreg(8'h70, 8'(k));
            repeat (600) @(posedge clk);
            send(14'd100, 14'd100 + 14'(AMP_TBL[k]));
        end
        wreg(8'h70, 8'h00);
        wreg(8'h70, 8'h24);
        lo = 14'h3fff;
        hi = 14'h0000;
        repeat (1400)
        begin
            @(posedge clk);
            rx_v <= 1'b1;
            rx_s <= 14'd100;
            @(negedge clk);
            if (rxo_v === 1'b1 && rxo_s < lo)
                lo = rxo_s;
            if (rxo_v === 1'b1 && rxo_s > hi)
                hi = rxo_s;
        end
        @(posedge clk);
        rx_v <= 1'b0;
        check("ramp low", {18'h0, lo}, 32'd100);
        check("ramp peak", {18'h0, hi}, 32'd115);
        wreg(8'h70, 8'h00);
        $display("test sample done");

        wreg(8'h7e, 8'h01);
        wreg(8'h71, 8'h10);
        @(posedge clk);
        pulses(na, nc);
        check("aux pulses", 32'(na), 32'd5);
        check("coef pulses", 32'(nc), 32'd10);
        @(posedge clk);
        frozen <= 1'b1;
        @(posedge clk);
        pulses(na, nc);
        check("frozen pulses", 32'(na + nc), 32'd0);
        @(posedge clk);
        frozen <= 1'b0;
        $display("test spring done");

        wreg(8'h73, 8'h00);
        wreg(8'h74, 8'h31);
        nv_run(1'b0, t_off);
        nv_run(1'b1, t_on);
        check("hang over", {31'h0, t_on > t_off + 500}, 32'h1);
        $display("test no voice done");

        wreg(8'h72, 8'h0f);
        mode_a <= 1'b1;
        mode_b <= 1'b1;
        chan   <= 5'd4;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check("long mode", {31'h0, long_m}, 32'h1);
        check("long delay", {28'h0, eff_dly}, 32'hf);
        check("master ch4", {31'h0, owned}, 32'h0);
        @(posedge clk);
        chan <= 5'd11;
        repeat (2) @(negedge clk);
        check("master ch11", {31'h0, owned}, 32'h1);
        wreg(8'h7e, 8'h09);
        chan <= 5'd28;
        repeat (2) @(negedge clk);
        check("slave ch28", {31'h0, owned}, 32'h1);
        $display("test long mode done");
        test_done();
    end
endmodule
`default_nettype wire
